// ==== bench/osc_asserts.sv ====
// Port-level checker for the OTP security configuration block
`default_nettype none
module osc_asserts
  import osc_pkg::*;
#(
  parameter logic [osc_pkg::OSC_REV_W-1:0] SILICON_REV = 8'h5A,
  parameter logic [osc_pkg::OSC_WORD_W-1:0] FLASH_BOOT_ADDR = 32'h0000_0000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // Requests
  input wire logic psel,
  input wire logic penable,
  input wire logic [osc_pkg::OSC_PCTL_W-1:0] prog_ctrl,
  input wire logic dbg_req,
  // Answers
  input wire logic pready,
  input wire logic prog_done,
  input wire logic prog_err,
  input wire logic dbg_ack,
  input wire logic dbg_err,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] dbg_rdata,
  // Gates and boot
  input wire logic dbg_tile_allow,
  input wire logic copy_valid,
  input wire logic [osc_pkg::OSC_IDX_W-1:0] copy_addr,
  input wire logic boot_go,
  input wire logic boot_from_otp,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] boot_addr,
  input wire logic cpu_run,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] usercode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_prog_answer: assert property (pce && prog_ctrl[0] |=> prog_done)
    else $error("programming request not answered");
  a_prog_early: assert property (pce && prog_ctrl[0] && !cpu_run |=> prog_err)
    else $error("programming accepted before run");
  a_err_paired: assert property (prog_err |-> prog_done)
    else $error("programming error without done");
  a_dbg_refuse: assert property (
    pce && dbg_req && cpu_run && !dbg_tile_allow |=> dbg_ack && dbg_err)
    else $error("debug access not refused");
  a_dbg_zero: assert property (dbg_ack && dbg_err |-> dbg_rdata == '0)
    else $error("refused debug read returned data");
  a_copy_seq: assert property (
    copy_valid && copy_addr != OSC_LAST_IDX
    |=> copy_valid && copy_addr == $past(copy_addr) + 1'b1)
    else $error("copy address sequence broken");
  a_boot_after: assert property (
    boot_go |-> $past(copy_valid) && $past(copy_addr) == OSC_LAST_IDX)
    else $error("boot before last copy word");
  a_run_copy: assert property (copy_valid |-> !cpu_run)
    else $error("core runs during copy");
  a_otp_boot: assert property (
    cpu_run && boot_from_otp |-> boot_addr == OSC_OTP_BOOT_ADDR)
    else $error("wrong otp boot address");
  a_flash_boot: assert property (
    cpu_run && !boot_from_otp |-> boot_addr == FLASH_BOOT_ADDR)
    else $error("wrong flash boot address");
  a_user_low: assert property (cpu_run |-> usercode[21:0] == {14'h0000, SILICON_REV})
    else $error("usercode low part wrong");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule : osc_asserts
bind osc_top osc_asserts #(.SILICON_REV(SILICON_REV), .FLASH_BOOT_ADDR(FLASH_BOOT_ADDR)) chk (
  .pclk, .presetn, .pce, .psel, .penable, .prog_ctrl, .dbg_req, .pready, .prog_done,
  .prog_err, .dbg_ack, .dbg_err, .dbg_rdata, .dbg_tile_allow, .copy_valid, .copy_addr,
  .boot_go, .boot_from_otp, .boot_addr, .cpu_run, .usercode);
`default_nettype wire

// ==== bench/osc_core_model.sv ====
// Processor-core model driving the OTP programming ports
`default_nettype none
module osc_core_model (
  // Clock
  input wire logic pclk,
  // Programming ports
  output logic [osc_pkg::OSC_PADR_W-1:0] prog_addr,
  output logic [osc_pkg::OSC_WORD_W-1:0] prog_data,
  output logic [osc_pkg::OSC_PCTL_W-1:0] prog_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  import osc_pkg::*;
  initial begin
    prog_addr = '0;
    prog_data = '0;
    prog_ctrl = '0;
  end
  // Released address and data are scrambled so stale values are never trusted
  task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic s, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    prog_addr <= a;
    prog_data <= d;
    prog_ctrl <= {14'h0000, s, 1'b1};
    @(posedge pclk);
    prog_addr <= ~a;
    prog_data <= ~d;
    prog_ctrl <= 16'h0000;
  endtask : prog
endmodule : osc_core_model
`default_nettype wire

// ==== bench/osc_top_test.sv ====
// Self-checking testbench for the OTP security configuration block
`default_nettype none
module osc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import osc_pkg::*;
  localparam logic [7:0] REV = 8'hC3;
  localparam logic [31:0] FADR = 32'h0000_4000;
  logic pclk = 0, presetn = 0, pce = 1, por_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, prog_data, copy_data, boot_addr, usercode, d, s;
  logic [15:0] prog_addr, prog_ctrl, dbg_addr = '0;
  logic prog_done, prog_err, dbg_req = 0, dbg_we = 0, dbg_ack, dbg_err;
  logic [31:0] dbg_wdata = '0, dbg_rdata, rng = 32'h0001_1F3C, w203 = '0;
  logic dbg_tile_allow, link_allow, redund_en, copy_valid, boot_go, boot_from_otp, cpu_run;
  logic [10:0] copy_addr;
  int err_count = 0, checks_done = 0, cyc = 0, ncopy = 0;
  logic [32:0] q_apb[$], q_dbg[$];
  logic q_prog[$];
  osc_top #(.SILICON_REV(REV), .FLASH_BOOT_ADDR(FADR)) uut (
    .pclk, .presetn, .pce, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .prog_addr, .prog_data, .prog_ctrl, .prog_done, .prog_err, .dbg_req,
    .dbg_we, .dbg_addr, .dbg_wdata, .dbg_ack, .dbg_err, .dbg_rdata, .dbg_tile_allow,
    .link_allow, .redund_en, .copy_valid, .copy_addr, .copy_data, .boot_go, .boot_from_otp,
    .boot_addr, .cpu_run, .usercode);
  osc_core_model core (.pclk, .prog_addr, .prog_data, .prog_ctrl);
  always #20 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w) q_apb.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pg(input logic [15:0] a, input logic [31:0] v, input logic t, input logic e);
    q_prog.push_back(e);
    core.prog(a, v, t, int'(rnd() & 32'h3));
  endtask : pg
  task automatic dbg(input logic w, input logic [15:0] a, input logic [32:0] e);
    @(posedge pclk);
    dbg_req <= 1'b1;
    dbg_we <= w;
    dbg_addr <= a;
    dbg_wdata <= rnd();
    q_dbg.push_back(e);
    @(posedge pclk);
    dbg_req <= 1'b0;
    dbg_addr <= ~a;
  endtask : dbg
  task automatic boot(input logic [31:0] v);
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 2100 && cpu_run !== 1'b1; i++) @(posedge pclk);
    chk("copies", 33'h800, 33'(ncopy));
    chk("gates", 33'({~v[0], ~v[1], v[7], v[5]}),
      33'({dbg_tile_allow, link_allow, redund_en, boot_from_otp}));
    chk("boot_addr", {1'b0, v[5] ? OSC_OTP_BOOT_ADDR : FADR}, {1'b0, boot_addr});
    chk("usercode", {1'b0, v[31:22], 14'h0000, REV}, {1'b0, usercode});
    apb(1'b0, OSC_REG_SEC, 32'h0, {1'b0, v});
    apb(1'b0, OSC_REG_STATUS, 32'h0, 33'h0_0000_000F);
    $display("boot with word %h done", v);
  endtask : boot
  task automatic reload();
    apb(1'b1, OSC_REG_CTRL, 32'h0000_0003, 33'h0);
    ncopy = 0;
  endtask : reload
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    if (presetn && copy_valid) ncopy++;
    if (presetn && copy_valid && copy_addr == 11'h203)
      chk("copy_data", {1'b0, w203}, {1'b0, copy_data});
    if (pready && !pwrite) chk("apb", q_apb.pop_front(), {pslverr, prdata});
    if (prog_done) chk("prog", {32'h0, q_prog.pop_front()}, {32'h0, prog_err});
    if (dbg_ack) chk("dbg", q_dbg.pop_front(), {dbg_err, dbg_rdata});
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 12000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    por_n <= 1'b1;
    presetn <= 1'b1;
    boot(32'h0);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    d = rnd();
    pg(16'h0203, d, 1'b0, 1'b0);
    w203 = d;
    dbg(1'b0, 16'h0203, {1'b0, d});
    pg(16'h0803, d, 1'b0, 1'b1);
    s = (rnd() & 32'hFFFF_8000) | 32'h0000_21A3;
    pg(16'h0000, s, 1'b1, 1'b0);
    apb(1'b0, OSC_REG_SEC, 32'h0, 33'h0);
    reload();
    pg(16'h0007, rnd(), 1'b0, 1'b1);
    boot(s);
    for (int k = 0; k < 4; k++) pg({5'h00, 2'(k), 9'h005}, rnd(), 1'b0, k == 0);
    dbg(1'b0, 16'h0203, {1'b1, 32'h0});
    dbg(1'b1, 16'h0203, {1'b1, 32'h0});
    pg(16'h0000, 32'h0000_1000, 1'b1, 1'b0);
    reload();
    s = s | 32'h0000_1000;
    boot(s);
    for (int k = 0; k < 4; k++) pg({5'h00, 2'(k), 9'h007}, rnd(), 1'b0, 1'b1);
    pg(16'h0000, 32'h0000_0004, 1'b1, 1'b1);
    reload();
    boot(s);
    stop_test();
  end
endmodule : osc_top_test
`default_nettype wire

// ==== hdl/osc_pkg.sv ====
// Shared constants and types for the OTP security configuration block
`default_nettype none
package osc_pkg;
  // Memory organisation
  localparam int OSC_SECTORS = 4;
  localparam int OSC_ROWS = 512;
  localparam int OSC_WORD_W = 32;
  localparam int OSC_ROW_BITS = 9;
  localparam int OSC_SECT_BITS = 2;
  localparam int OSC_IDX_W = OSC_ROW_BITS + OSC_SECT_BITS;
  localparam logic [OSC_IDX_W-1:0] OSC_LAST_IDX = 11'h7FF;
  // Programming ports
  localparam int OSC_PADR_W = 16;
  localparam int OSC_PCTL_W = 16;
  localparam int OSC_CTL_GO = 0;
  localparam int OSC_CTL_SEC = 1;
  // Security register fields
  localparam int OSC_SEC_NO_DBG = 0;
  localparam int OSC_SEC_NO_LINK = 1;
  localparam int OSC_SEC_OTP_BOOT = 5;
  localparam int OSC_SEC_REDUND = 7;
  localparam int OSC_SEC_LOCK_LO = 8;
  localparam int OSC_SEC_MASTER = 12;
  localparam int OSC_SEC_NO_DBG_OTP = 13;
  localparam int OSC_SEC_GP_LO = 15;
  localparam int OSC_SEC_GP_HI = 21;
  localparam int OSC_SEC_UID_LO = 22;
  localparam int OSC_SEC_UID_HI = 31;
  localparam logic [OSC_WORD_W-1:0] OSC_SEC_RESET = 32'h0000_0000;
  // User-code layout: identifier, zero pad, revision
  localparam int OSC_REV_W = 8;
  localparam int OSC_UC_PAD_W = 14;
  // Boot
  localparam logic [OSC_WORD_W-1:0] OSC_OTP_BOOT_ADDR = 32'h0000_0000;
  // APB map
  localparam int OSC_PADDR_W = 8;
  localparam logic [OSC_PADDR_W-1:0] OSC_REG_SEC = 8'h00;
  localparam logic [OSC_PADDR_W-1:0] OSC_REG_STATUS = 8'h04;
  localparam logic [OSC_PADDR_W-1:0] OSC_REG_CTRL = 8'h08;
  localparam logic [OSC_PADDR_W-1:0] OSC_REG_USER = 8'h0C;
  localparam int OSC_CTRL_PROG_EN = 0;
  localparam int OSC_CTRL_RELOAD = 1;
  localparam logic [OSC_WORD_W-1:0] OSC_CTRL_RESET = 32'h0000_0001;
  localparam int OSC_STAT_PAD_W = 28;

  typedef enum logic [1:0] {
    OSC_ST_LOAD,
    OSC_ST_COPY,
    OSC_ST_BOOT,
    OSC_ST_RUN
  } osc_state_t;
endpackage : osc_pkg
`default_nettype wire

// ==== hdl/osc_store.sv ====
// One-time-programmable array and stored security word, held in flip-flops
`default_nettype none
module osc_store #(
  parameter int SECTORS = 4,
  parameter int ROWS = 512,
  parameter int WIDTH = 32,
  parameter int IDX_W = 11
) (
  // Clock and power-on erase
  input wire logic clk,
  input wire logic por_n,
  input wire logic ce,
  // Program port
  input wire logic wr_en,
  input wire logic wr_sec,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  output logic [WIDTH-1:0] sec_word
);
  localparam int DEPTH = SECTORS * ROWS;

  logic [WIDTH-1:0] mem [DEPTH];

  // Fuse bits only ever go from 0 to 1, except at the power-on erase, which clears them all
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      sec_word <= '0;
    end else if (ce && wr_en) begin
      if (wr_sec) begin
        sec_word <= sec_word | wr_data;
      end else begin
        mem[wr_idx] <= mem[wr_idx] | wr_data;
      end
    end
  end

  assign rd_data = mem[rd_idx];
endmodule : osc_store
`default_nettype wire

// ==== hdl/osc_top.sv ====
// OTP security configuration: power-up load, copy-out, boot select, locks, APB view
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module osc_top
  import osc_pkg::*;
#(
  parameter int SECTORS = osc_pkg::OSC_SECTORS,
  parameter int ROWS = osc_pkg::OSC_ROWS,
  parameter logic [osc_pkg::OSC_REV_W-1:0] SILICON_REV = 8'h5A, // arbitrary value
  parameter logic [osc_pkg::OSC_WORD_W-1:0] FLASH_BOOT_ADDR = 32'h0000_0000
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic por_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [osc_pkg::OSC_PADDR_W-1:0] paddr,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] pwdata,
  output logic [osc_pkg::OSC_WORD_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core programming ports
  input wire logic [osc_pkg::OSC_PADR_W-1:0] prog_addr,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] prog_data,
  input wire logic [osc_pkg::OSC_PCTL_W-1:0] prog_ctrl,
  output logic prog_done,
  output logic prog_err,
  // Debug-port OTP access
  input wire logic dbg_req,
  input wire logic dbg_we,
  input wire logic [osc_pkg::OSC_PADR_W-1:0] dbg_addr,
  input wire logic [osc_pkg::OSC_WORD_W-1:0] dbg_wdata,
  output logic dbg_ack,
  output logic dbg_err,
  output logic [osc_pkg::OSC_WORD_W-1:0] dbg_rdata,
  // Protection gates
  output logic dbg_tile_allow,
  output logic link_allow,
  output logic redund_en,
  // Copy to working memory
  output logic copy_valid,
  output logic [osc_pkg::OSC_IDX_W-1:0] copy_addr,
  output logic [osc_pkg::OSC_WORD_W-1:0] copy_data,
  // Boot control
  output logic boot_go,
  output logic boot_from_otp,
  output logic [osc_pkg::OSC_WORD_W-1:0] boot_addr,
  output logic cpu_run,
  output logic [osc_pkg::OSC_WORD_W-1:0] usercode
);
  import osc_pkg::*;

  function automatic logic [OSC_IDX_W-1:0] to_idx(input logic [OSC_PADR_W-1:0] a);
    return a[OSC_IDX_W-1:0];
  endfunction : to_idx

  // Whether a programming request may alter the target
  function automatic logic prog_ok(input logic [OSC_PADR_W-1:0] a, input logic to_sec,
                                   input logic [OSC_WORD_W-1:0] s);
    logic [OSC_SECT_BITS-1:0] sect;
    sect = a[OSC_ROW_BITS +: OSC_SECT_BITS];
    if (s[OSC_SEC_MASTER]) begin
      return 1'b0;
    end
    if (to_sec) begin
      return 1'b1;
    end
    if (a[OSC_PADR_W-1:OSC_IDX_W] != '0) begin
      return 1'b0;
    end
    return ~s[OSC_SEC_LOCK_LO + int'(sect)];
  endfunction : prog_ok

  // Boot sequence state
  osc_state_t state, next_state;
  logic [OSC_IDX_W-1:0] copy_idx, next_copy_idx;
  logic [OSC_WORD_W-1:0] sec, next_sec;
  logic loaded, next_loaded;
  logic next_copy_valid, next_boot_go, next_boot_from_otp, next_cpu_run;
  logic [OSC_IDX_W-1:0] next_copy_addr;
  logic [OSC_WORD_W-1:0] next_copy_data, next_boot_addr, next_usercode;
  logic next_dbg_tile_allow, next_link_allow, next_redund_en;
  // APB state
  logic [OSC_WORD_W-1:0] ctrl, next_ctrl, next_prdata;
  logic reload_req, next_reload_req, next_pready, next_pslverr;
  // Programming and debug results
  logic next_prog_done, next_prog_err, next_dbg_ack, next_dbg_err;
  logic [OSC_WORD_W-1:0] next_dbg_rdata;
  // Storage connections
  logic wr_en, wr_sec;
  logic [OSC_IDX_W-1:0] wr_idx, rd_idx;
  logic [OSC_WORD_W-1:0] wr_data, rd_data, sec_word;
  logic run, core_go, core_ok, core_wr, dbg_blocked, dbg_ok, dbg_wr;

  osc_store #(
    .SECTORS(SECTORS),
    .ROWS(ROWS),
    .WIDTH(OSC_WORD_W),
    .IDX_W(OSC_IDX_W)
  ) u_store (
    .clk(pclk),
    .por_n(por_n),
    .ce(pce),
    .wr_en(wr_en),
    .wr_sec(wr_sec),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .sec_word(sec_word)
  );

  assign run = (state == OSC_ST_RUN);
  assign rd_idx = run ? to_idx(dbg_addr) : copy_idx;

  // Boot sequence: load, copy, boot, run
  always_comb begin
    next_state = state;
    next_copy_idx = copy_idx;
    next_sec = sec;
    next_loaded = loaded;
    next_copy_valid = 1'b0;
    next_copy_addr = copy_addr;
    next_copy_data = copy_data;
    next_boot_go = 1'b0;
    next_boot_from_otp = boot_from_otp;
    next_boot_addr = boot_addr;
    next_cpu_run = cpu_run;
    case (state)
      OSC_ST_LOAD: begin
        next_sec = sec_word;
        next_loaded = 1'b1;
        next_copy_idx = '0;
        next_cpu_run = 1'b0;
        next_state = OSC_ST_COPY;
      end
      OSC_ST_COPY: begin
        next_copy_valid = 1'b1;
        next_copy_addr = copy_idx;
        next_copy_data = rd_data;
        if (copy_idx == OSC_LAST_IDX) begin
          next_state = OSC_ST_BOOT;
        end else begin
          next_copy_idx = copy_idx + 1'b1;
        end
      end
      OSC_ST_BOOT: begin
        next_boot_go = 1'b1;
        next_boot_from_otp = sec[OSC_SEC_OTP_BOOT];
        next_boot_addr = sec[OSC_SEC_OTP_BOOT] ? OSC_OTP_BOOT_ADDR :
          FLASH_BOOT_ADDR;
        next_cpu_run = 1'b1;
        next_state = OSC_ST_RUN;
      end
      OSC_ST_RUN: begin
        if (reload_req) begin
          next_loaded = 1'b0;
          next_cpu_run = 1'b0;
          next_state = OSC_ST_LOAD;
        end
      end
      default: begin
        next_state = OSC_ST_LOAD;
      end
    endcase
    // Gates stay closed until the register is loaded
    next_dbg_tile_allow = next_loaded & ~next_sec[OSC_SEC_NO_DBG];
    next_link_allow = next_loaded & ~next_sec[OSC_SEC_NO_LINK];
    next_redund_en = next_loaded & next_sec[OSC_SEC_REDUND];
    next_usercode = {next_sec[OSC_SEC_UID_HI:OSC_SEC_UID_LO], {OSC_UC_PAD_W{1'b0}},
                     SILICON_REV};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OSC_ST_LOAD;
      copy_idx <= '0;
      sec <= OSC_SEC_RESET;
      loaded <= 1'b0;
      copy_valid <= 1'b0;
      copy_addr <= '0;
      copy_data <= '0;
      boot_go <= 1'b0;
      boot_from_otp <= 1'b0;
      boot_addr <= '0;
      cpu_run <= 1'b0;
      dbg_tile_allow <= 1'b0;
      link_allow <= 1'b0;
      redund_en <= 1'b0;
      usercode <= '0;
    end else if (pce) begin
      state <= next_state;
      copy_idx <= next_copy_idx;
      sec <= next_sec;
      loaded <= next_loaded;
      copy_valid <= next_copy_valid;
      copy_addr <= next_copy_addr;
      copy_data <= next_copy_data;
      boot_go <= next_boot_go;
      boot_from_otp <= next_boot_from_otp;
      boot_addr <= next_boot_addr;
      cpu_run <= next_cpu_run;
      dbg_tile_allow <= next_dbg_tile_allow;
      link_allow <= next_link_allow;
      redund_en <= next_redund_en;
      usercode <= next_usercode;
    end
  end

  // Programming from the core and from the debug port
  always_comb begin
    core_go = prog_ctrl[OSC_CTL_GO];
    core_ok = run & ctrl[OSC_CTRL_PROG_EN] & prog_ok(prog_addr, prog_ctrl[OSC_CTL_SEC], sec);
    core_wr = core_go & core_ok;
    dbg_blocked = ~run | sec[OSC_SEC_NO_DBG] | sec[OSC_SEC_NO_DBG_OTP];
    dbg_ok = prog_ok(dbg_addr, 1'b0, sec);
    dbg_wr = dbg_req & dbg_we & ~dbg_blocked & ~core_go & dbg_ok;
    wr_en = core_wr | dbg_wr;
    wr_sec = core_wr & prog_ctrl[OSC_CTL_SEC];
    wr_idx = core_wr ? to_idx(prog_addr) : to_idx(dbg_addr);
    wr_data = core_wr ? prog_data : dbg_wdata;
    next_prog_done = core_go;
    next_prog_err = core_go & ~core_ok;
    next_dbg_ack = dbg_req;
    next_dbg_err = dbg_req & (dbg_blocked | (dbg_we & (core_go | ~dbg_ok)));
    next_dbg_rdata = (dbg_req & ~dbg_we & ~dbg_blocked) ? rd_data : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_done <= 1'b0;
      prog_err <= 1'b0;
      dbg_ack <= 1'b0;
      dbg_err <= 1'b0;
      dbg_rdata <= '0;
    end else if (pce) begin
      prog_done <= next_prog_done;
      prog_err <= next_prog_err;
      dbg_ack <= next_dbg_ack;
      dbg_err <= next_dbg_err;
      dbg_rdata <= next_dbg_rdata;
    end
  end

  // APB slave: one access cycle, read data latched at setup
  always_comb begin
    logic setup;
    logic commit;
    logic mapped;
    setup = psel & ~penable;
    commit = psel & penable & pready;
    mapped = (paddr == OSC_REG_SEC) || (paddr == OSC_REG_STATUS) ||
             (paddr == OSC_REG_CTRL) || (paddr == OSC_REG_USER);
    next_pready = setup;
    next_pslverr = setup & ~mapped;
    next_prdata = prdata;
    next_ctrl = ctrl;
    next_reload_req = 1'b0;
    if (setup) begin
      case (paddr)
        OSC_REG_SEC: next_prdata = sec;
        OSC_REG_STATUS: next_prdata = {{OSC_STAT_PAD_W{1'b0}}, cpu_run, loaded, state};
        OSC_REG_CTRL: next_prdata = ctrl;
        OSC_REG_USER: next_prdata = usercode;
        default: next_prdata = '0;
      endcase
    end
    if (commit && pwrite && paddr == OSC_REG_CTRL) begin
      next_ctrl = '0;
      next_ctrl[OSC_CTRL_PROG_EN] = pwdata[OSC_CTRL_PROG_EN];
      next_reload_req = pwdata[OSC_CTRL_RELOAD];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= OSC_CTRL_RESET;
      reload_req <= 1'b0;
    end else if (pce) begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ctrl <= next_ctrl;
      reload_req <= next_reload_req;
    end
  end
endmodule : osc_top
`default_nettype wire
